// ==== src/rx_comm_control.sv ====
// Feedback packet framer, load modulator and supervisory control of the receiver.
`include "rx_comm_regs.svh"

module rx_comm_control #(
  parameter logic [23:0] HALF_BIT_CYC = 24'(`HALF_BIT_CYC),
  parameter logic [23:0] TEMP_BIAS_PIN_CYC = 24'(`MS_CYC(`TEMP_BIAS_PIN_MS)),
  parameter logic [23:0] TS_DEGLITCH_CYC = 24'(`MS_CYC(`TS_DEGLITCH_MS)),
  parameter logic [23:0] TS_PRIO_CYC = 24'(`MS_CYC(`TS_PRIO_MS)),
  parameter logic [23:0] TS_STD_CYC = 24'(`MS_CYC(`TS_STD_MS)),
  parameter logic [23:0] ERR_FAST_CYC = 24'(`MS_CYC(`ERR_FAST_MS)),
  parameter logic [23:0] ERR_SLOW_CYC = 24'(`MS_CYC(`ERR_SLOW_MS))
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic vrect_converged,
  input wire logic vrect_at_target,
  input wire logic vrect_above_uvlo,
  input wire logic supply_enable_req,
  input wire logic [9:0] load_ma,
  input wire logic [7:0] byte_data,
  input wire logic byte_valid,
  input wire logic byte_last,
  input wire logic ts_hot_cmp,
  input wire logic ts_cold_cmp,
  input wire logic temp_control_pin_cmp,
  output logic byte_ready_r,
  output logic frame_busy_r,
  output logic modulation_switch_a_r,
  output logic modulation_switch_b_r,
  output logic supply_enable_r,
  output logic power_good_status_n_o_r,
  output logic power_good_status_n_oe_r,
  output logic [10:0] comm_ilim_ma_r,
  output rx_comm_pkg::rect_mode_e rect_mode_r,
  output logic temp_bias_window_r,
  output logic temp_bias_pin_o_r,
  output logic temp_bias_pin_oe_r,
  output logic temp_hot_r,
  output logic temp_cold_r,
  output logic temp_control_r,
  output logic err_pkt_due_r
);

  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic conv_s;
  logic target_s;
  logic uvlo_s;
  logic hot_s;
  logic cold_s;
  logic ctrl_s;
  rx_comm_pkg::frame_state_e state_r;
  logic [10:0] sh_r;
  logic [3:0] bit_idx_r;
  logic [23:0] half_cnt_r;
  logic phase_r;
  logic mod_r;
  logic [7:0] chk_r;
  logic last_r;
  logic ck_sent_r;
  logic half_tick;
  logic char_done;
  logic take_byte;
  logic load_char;
  logic [7:0] load_data;
  logic mod_nxt;
  rx_comm_pkg::ts_phase_e ts_phase_r;
  logic [23:0] ts_cnt_r;
  logic [23:0] ts_lim;
  logic ts_end;
  logic ctrl_seen_r;
  logic hot_f;
  logic cold_f;
  logic [23:0] err_cnt_r;
  logic [23:0] err_lim;

  // Pin-level inputs cross into the timebase through two flip-flops.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end
    else
    begin
      sync1_r <= {temp_control_pin_cmp, ts_cold_cmp, ts_hot_cmp,
                  vrect_above_uvlo, vrect_at_target, vrect_converged};
      sync2_r <= sync1_r;
    end
  end

  assign conv_s = sync2_r[0];
  assign target_s = sync2_r[1];
  assign uvlo_s = sync2_r[2];
  assign hot_s = sync2_r[3];
  assign cold_s = sync2_r[4];
  assign ctrl_s = sync2_r[5];

  // Supply enable needs convergence; status pin pulls low while it is on.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      supply_enable_r <= 1'b0;
      power_good_status_n_o_r <= 1'b0;
      power_good_status_n_oe_r <= 1'b0;
    end
    else
    begin
      supply_enable_r <= supply_enable_req && conv_s;
      power_good_status_n_o_r <= 1'b0;
      power_good_status_n_oe_r <= supply_enable_r;
    end
  end

  // Bit timing: two half-bit ticks make one bit period.
  assign half_tick = state_r == rx_comm_pkg::FR_SEND && half_cnt_r == HALF_BIT_CYC - 24'h000001;
  assign char_done = half_tick && phase_r && bit_idx_r == `CHAR_LAST_BIT;
  assign take_byte = byte_valid && (state_r == rx_comm_pkg::FR_IDLE ||
                     state_r == rx_comm_pkg::FR_WAIT);
  // The checksum follows straight on after the last message character.
  assign load_char = take_byte || (char_done && last_r && !ck_sent_r);
  assign load_data = take_byte ? byte_data : chk_r;

  // Framer sequencing: header, message bytes, then the checksum character.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_r <= rx_comm_pkg::FR_IDLE;
      last_r <= 1'b0;
      ck_sent_r <= 1'b0;
      chk_r <= 8'h00;
    end
    else if (take_byte)
    begin
      state_r <= rx_comm_pkg::FR_SEND;
      last_r <= byte_last;
      ck_sent_r <= 1'b0;
      chk_r <= (state_r == rx_comm_pkg::FR_IDLE) ? byte_data : chk_r ^ byte_data;
    end
    else if (load_char)
    begin
      ck_sent_r <= 1'b1;
    end
    else if (char_done)
    begin
      state_r <= ck_sent_r ? rx_comm_pkg::FR_IDLE : rx_comm_pkg::FR_WAIT;
    end
  end

  // Character shifter; parity is odd over the data byte alone.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sh_r <= 11'h000;
      bit_idx_r <= 4'h0;
    end
    else if (load_char)
    begin
      sh_r <= {`STOP_BIT, ~^load_data, load_data, `START_BIT};
      bit_idx_r <= 4'h0;
    end
    else if (half_tick && phase_r)
    begin
      sh_r <= {1'b0, sh_r[10:1]};
      bit_idx_r <= bit_idx_r + 4'h1;
    end
  end

  // Half-bit counter and phase within the current bit.
  always_ff @(posedge ref_clk)
  begin
    if (rst || load_char || half_tick)
    begin
      half_cnt_r <= 24'h000000;
    end
    else if (state_r == rx_comm_pkg::FR_SEND)
    begin
      half_cnt_r <= half_cnt_r + 24'h000001;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst || load_char)
    begin
      phase_r <= 1'b0;
    end
    else if (half_tick)
    begin
      phase_r <= ~phase_r;
    end
  end

  // Differential biphase: toggle at the start of each bit, and mid-bit for a one.
  always_comb
  begin
    mod_nxt = mod_r;
    if (load_char || (half_tick && phase_r && !char_done))
    begin
      mod_nxt = ~mod_r;
    end
    else if (half_tick && !phase_r && sh_r[0])
    begin
      mod_nxt = ~mod_r;
    end
  end

  // Both switches share one level so they may be used singly or paralleled.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      mod_r <= 1'b0;
      modulation_switch_a_r <= 1'b0;
      modulation_switch_b_r <= 1'b0;
      byte_ready_r <= 1'b0;
      frame_busy_r <= 1'b0;
    end
    else
    begin
      mod_r <= mod_nxt;
      modulation_switch_a_r <= mod_nxt;
      modulation_switch_b_r <= mod_nxt;
      byte_ready_r <= take_byte;
      frame_busy_r <= state_r != rx_comm_pkg::FR_IDLE || take_byte;
    end
  end

  // Communication current limit, so load noise is not mistaken for data.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      comm_ilim_ma_r <= `ILIM_FIXED_MA;
    end
    else if (load_ma > `ILIM_KNEE_MA)
    begin
      comm_ilim_ma_r <= {1'b0, load_ma} + `ILIM_MARGIN_MA;
    end
    else
    begin
      comm_ilim_ma_r <= `ILIM_FIXED_MA;
    end
  end

  // Rectifier mode with 120 / 100 mA hysteresis to avoid chattering.
  always_ff @(posedge ref_clk)
  begin
    if (rst || !uvlo_s)
    begin
      rect_mode_r <= rx_comm_pkg::RECT_OFF;
    end
    else
    begin
      unique case (rect_mode_r)
        rx_comm_pkg::RECT_OFF: rect_mode_r <= rx_comm_pkg::RECT_HALF;
        rx_comm_pkg::RECT_HALF:
          if (load_ma > `FULL_ON_MA)
          begin
            rect_mode_r <= rx_comm_pkg::RECT_FULL;
          end
        rx_comm_pkg::RECT_FULL:
          if (load_ma < `FULL_OFF_MA)
          begin
            rect_mode_r <= rx_comm_pkg::RECT_HALF;
          end
        default: rect_mode_r <= rx_comm_pkg::RECT_OFF;
      endcase
    end
  end

  // Hot and cold comparators are filtered and only trusted under bias.
  level_deglitch #(.HOLD_CYC(TS_DEGLITCH_CYC)) u_hot_filt (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(ts_phase_r == rx_comm_pkg::TS_MON),
    .din(hot_s),
    .dout_r(hot_f)
  );

  level_deglitch #(.HOLD_CYC(TS_DEGLITCH_CYC)) u_cold_filt (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(ts_phase_r == rx_comm_pkg::TS_MON),
    .din(cold_s),
    .dout_r(cold_f)
  );

  // The unbiased interval is short while error packets come quickly.
  assign ts_lim = (ts_phase_r == rx_comm_pkg::TEMP_BIAS_PIN) ? TEMP_BIAS_PIN_CYC :
                  (target_s ? TS_STD_CYC : TS_PRIO_CYC);
  assign ts_end = ts_cnt_r == ts_lim - 24'h000001;

  // Temperature sense cycle: biased window, then control-pin watch.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ts_phase_r <= rx_comm_pkg::TEMP_BIAS_PIN;
      ts_cnt_r <= 24'h000000;
      ctrl_seen_r <= 1'b0;
    end
    else if (ts_end)
    begin
      ts_phase_r <= (ts_phase_r == rx_comm_pkg::TEMP_BIAS_PIN) ? rx_comm_pkg::TS_MON :
                    rx_comm_pkg::TEMP_BIAS_PIN;
      ts_cnt_r <= 24'h000000;
      ctrl_seen_r <= 1'b0;
    end
    else
    begin
      ts_cnt_r <= ts_cnt_r + 24'h000001;
      if (ts_phase_r == rx_comm_pkg::TS_MON && ctrl_s)
      begin
        ctrl_seen_r <= 1'b1;
      end
    end
  end

  // Results are latched at each phase end so they stay stable between reads.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      temp_hot_r <= 1'b0;
      temp_cold_r <= 1'b0;
      temp_control_r <= 1'b0;
    end
    else if (ts_end && ts_phase_r == rx_comm_pkg::TEMP_BIAS_PIN)
    begin
      temp_hot_r <= hot_f;
      temp_cold_r <= cold_f;
    end
    else if (ts_end)
    begin
      temp_control_r <= ctrl_seen_r || ctrl_s;
    end
  end

  // Bias pin drives only inside the window and floats otherwise.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      temp_bias_window_r <= 1'b0;
      temp_bias_pin_o_r <= 1'b1;
      temp_bias_pin_oe_r <= 1'b0;
    end
    else
    begin
      temp_bias_window_r <= ts_phase_r == rx_comm_pkg::TEMP_BIAS_PIN;
      temp_bias_pin_o_r <= 1'b1;
      temp_bias_pin_oe_r <= ts_phase_r == rx_comm_pkg::TEMP_BIAS_PIN;
    end
  end

  // Error packet pacing; a shorter limit takes effect at once.
  assign err_lim = target_s ? ERR_SLOW_CYC : ERR_FAST_CYC;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      err_cnt_r <= 24'h000000;
      err_pkt_due_r <= 1'b0;
    end
    else if (err_cnt_r >= err_lim - 24'h000001)
    begin
      err_cnt_r <= 24'h000000;
      err_pkt_due_r <= 1'b1;
    end
    else
    begin
      err_cnt_r <= err_cnt_r + 24'h000001;
      err_pkt_due_r <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_mid_tick;
    half_tick && !phase_r;
  endsequence

  sequence s_window_end;
    $fell(temp_bias_window_r);
  endsequence

  chk_status_follows: assert property (power_good_status_n_oe_r == $past(supply_enable_r))
    else $error("status pin does not follow supply enable");
  chk_supply_needs_conv: assert property ($rose(supply_enable_r) |-> $past(conv_s))
    else $error("supply enabled before convergence");
  chk_mod_on_tick: assert property ($changed(mod_r) |-> $past(half_tick) || $past(load_char))
    else $error("modulation changed off the half-bit grid");
  chk_mid_bit_one: assert property (s_mid_tick |=> $changed(mod_r) == $past(sh_r[0]))
    else $error("mid-bit transition does not match data bit");
  chk_char_frame: assert property (load_char |=> !sh_r[0] && sh_r[10] && ^sh_r[9:1])
    else $error("character framing or odd parity wrong");
  chk_switch_pair: assert property (modulation_switch_a_r == modulation_switch_b_r)
    else $error("modulation switches differ");
  chk_comm_limit: assert property (comm_ilim_ma_r == (($past(load_ma) > `ILIM_KNEE_MA) ?
    {1'b0, $past(load_ma)} + `ILIM_MARGIN_MA : `ILIM_FIXED_MA))
    else $error("communication current limit wrong");
  chk_rect_uvlo: assert property (!uvlo_s |=> rect_mode_r == rx_comm_pkg::RECT_OFF)
    else $error("rectifier active below lockout");
  chk_rect_up: assert property (uvlo_s && rect_mode_r == rx_comm_pkg::RECT_HALF &&
    load_ma > `FULL_ON_MA |=> rect_mode_r == rx_comm_pkg::RECT_FULL)
    else $error("full synchronous mode not entered");
  chk_rect_hold: assert property (uvlo_s && rect_mode_r == rx_comm_pkg::RECT_FULL &&
    load_ma >= `FULL_OFF_MA |=> rect_mode_r == rx_comm_pkg::RECT_FULL)
    else $error("full synchronous mode left too early");
  chk_bias_length: assert property (s_window_end |->
    $past(ts_cnt_r, 2) == TEMP_BIAS_PIN_CYC - 24'h000001)
    else $error("bias window length wrong");
  chk_bias_hiz: assert property (temp_bias_pin_oe_r == temp_bias_window_r)
    else $error("bias pin driven outside window");
  chk_err_spacing: assert property (err_pkt_due_r |->
    $past(err_cnt_r) >= $past(err_lim) - 24'h000001)
    else $error("error packet due too early");

endmodule

// ==== src/rx_comm_regs.svh ====
// Constants for the wireless receiver communication and control block.
`ifndef RX_COMM_REGS_SVH
`define RX_COMM_REGS_SVH

// Timebase and time figures in their own units.
`define CLK_HZ 40000000
`define BIT_PERIOD_US 500
`define TEMP_BIAS_PIN_MS 24
`define TS_DEGLITCH_MS 10
`define TS_PRIO_MS 35
`define TS_STD_MS 235
`define ERR_FAST_MS 30
`define ERR_SLOW_MS 250

// Cycle counts derived from the figures above.
`define HALF_BIT_CYC ((`BIT_PERIOD_US / 2) * (`CLK_HZ / 1000000))
`define MS_CYC(ms) ((ms) * (`CLK_HZ / 1000))

// Character framing.
`define CHAR_LAST_BIT 4'ha
`define START_BIT 1'b0
`define STOP_BIT 1'b1

// Current thresholds in mA.
`define ILIM_KNEE_MA 10'h12c
`define ILIM_FIXED_MA 11'h190
`define ILIM_MARGIN_MA 11'h032
`define FULL_ON_MA 10'h078
`define FULL_OFF_MA 10'h064

`endif

// ==== src/rx_comm_pkg.sv ====
// Types shared by the wireless receiver communication and control block.
package rx_comm_pkg;

  typedef enum logic [1:0]
  {
    RECT_OFF = 2'b00,
    RECT_HALF = 2'b01,
    RECT_FULL = 2'b10
  } rect_mode_e;

  typedef enum logic [1:0]
  {
    FR_IDLE = 2'b00,
    FR_WAIT = 2'b01,
    FR_SEND = 2'b10
  } frame_state_e;

  typedef enum logic
  {
    TEMP_BIAS_PIN = 1'b0,
    TS_MON = 1'b1
  } ts_phase_e;

endpackage

// ==== src/level_deglitch.sv ====
// Deglitch filter: the output follows a level only after it has held steady.
module level_deglitch #(
  parameter logic [23:0] HOLD_CYC = 24'h061a80
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic din,
  output logic dout_r
);

  logic [23:0] cnt_r;

  // Count cycles in which the input differs from the filtered level.
  always_ff @(posedge ref_clk)
  begin
    if (rst || clear || din == dout_r)
    begin
      cnt_r <= 24'h000000;
    end
    else
    begin
      cnt_r <= cnt_r + 24'h000001;
    end
  end

  // A clear drops the level so that a stale reading is never reused.
  always_ff @(posedge ref_clk)
  begin
    if (rst || clear)
    begin
      dout_r <= 1'b0;
    end
    else if (din != dout_r && cnt_r == HOLD_CYC - 24'h000001)
    begin
      dout_r <= din;
    end
  end

endmodule

// ==== verification/tx_demod_model.sv ====
// Transmitter-side demodulator model that decodes characters from the load switch line.
module tx_demod_model #(
  parameter int HALF = 8
) (
  input wire logic ref_clk,
  input wire logic line,
  output logic [7:0] rx_byte,
  output logic rx_strobe,
  output logic rx_frame_ok
);
  timeunit 1ns;
  timeprecision 1ps;

  logic prev;
  logic l1;
  logic [10:0] bits;

  // A transition on an idle line opens a character; each bit is read by comparing
  // the level a quarter and three quarters into it, so a one shows a mid toggle.
  initial
  begin
    rx_byte = 8'h00;
    rx_strobe = 1'b0;
    rx_frame_ok = 1'b0;
    repeat (8) @(posedge ref_clk);
    prev = line;
    forever
    begin
      @(posedge ref_clk);
      if (line !== prev)
      begin
        for (int i = 0; i < 11; i++)
        begin
          repeat (HALF / 2) @(posedge ref_clk);
          l1 = line;
          repeat (HALF) @(posedge ref_clk);
          bits[i] = l1 ^ line;
          if (i < 10)
            repeat (HALF / 2) @(posedge ref_clk);
        end
        rx_byte = bits[8:1];
        rx_frame_ok = !bits[0] && bits[10] && (^bits[9:1]);
        rx_strobe = 1'b1;
        @(posedge ref_clk);
        rx_strobe = 1'b0;
        prev = line;
      end
    end
  end
endmodule

// ==== verification/wireless_rx_comm_control_bench.sv ====
// Self-checking bench for the receiver communication and control block.
module wireless_rx_comm_control_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic vrect_converged = 1'b0;
  logic vrect_at_target = 1'b0;
  logic vrect_above_uvlo = 1'b0;
  logic supply_enable_req = 1'b0;
  logic [9:0] load_ma = 10'h000;
  logic [7:0] byte_data = 8'h00;
  logic byte_valid = 1'b0;
  logic byte_last = 1'b0;
  logic ts_hot_cmp = 1'b1;
  logic ts_cold_cmp = 1'b0;
  logic temp_control_pin_cmp = 1'b0;
  logic byte_ready_r, frame_busy_r, modulation_switch_a_r, modulation_switch_b_r;
  logic supply_enable_r, power_good_status_n_o_r, power_good_status_n_oe_r;
  logic [10:0] comm_ilim_ma_r;
  rx_comm_pkg::rect_mode_e rect_mode_r;
  logic temp_bias_window_r, temp_bias_pin_o_r, temp_bias_pin_oe_r;
  logic temp_hot_r, temp_cold_r, temp_control_r, err_pkt_due_r;
  logic [7:0] rx_byte;
  logic rx_strobe, rx_frame_ok;
  int err_count = 0;
  int checked = 0;
  int n;
  logic [2:0] ts_lv;
  logic [31:0] seed = 32'h000013c2;
  logic [7:0] exp_q[$];
  logic [7:0] got_q[$];
  int ilim_tab[6] = '{0, 299, 300, 301, 500, 1023};

  rx_comm_control #(.HALF_BIT_CYC(24'h000008), .TEMP_BIAS_PIN_CYC(24'h000028),
    .TS_DEGLITCH_CYC(24'h00000a), .TS_PRIO_CYC(24'h00001e), .TS_STD_CYC(24'h00003c),
    .ERR_FAST_CYC(24'h000014), .ERR_SLOW_CYC(24'h000032)) u_dut (.*);

  tx_demod_model #(.HALF(8)) u_tx (.ref_clk(ref_clk), .line(modulation_switch_a_r),
    .rx_byte(rx_byte), .rx_strobe(rx_strobe), .rx_frame_ok(rx_frame_ok));

  // Clock at 40 MHz.
  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
      err_count++;
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic step(input int c);
    repeat (c) @(posedge ref_clk);
  endtask

  // Counts edges while a flag keeps the given level; running out of bound fails.
  task automatic count_while(ref logic sig, input logic lvl, input int bound, output int c);
    c = 0;
    while (sig === lvl && c < bound)
    begin
      @(posedge ref_clk);
      c++;
    end
    if (c >= bound)
    begin
      $display("unexpected wait bound reached");
      err_count++;
      test_done();
    end
  endtask

  // Sends a packet; the model queue gets every byte plus the XOR checksum.
  task automatic send_packet(input int len, input logic [7:0] first);
    logic [7:0] b;
    logic [7:0] sum;
    int c;
    sum = 8'h00;
    for (int i = 0; i < len; i++)
    begin
      b = (i == 0) ? first : 8'(xs() >> 8);
      sum = sum ^ b;
      exp_q.push_back(b);
      byte_data <= b;
      byte_valid <= 1'b1;
      byte_last <= (i == len - 1);
      @(posedge ref_clk);
      count_while(byte_ready_r, 1'b0, 400, c);
      check("frame busy", 1, frame_busy_r);
    end
    exp_q.push_back(sum);
    byte_valid <= 1'b0;
    byte_last <= 1'b0;
    step(2);
    count_while(frame_busy_r, 1'b1, 800, c);
    step(400);
    check("byte count", exp_q.size(), got_q.size());
    while (exp_q.size() > 0 && got_q.size() > 0)
      check("rx byte", exp_q.pop_front(), got_q.pop_front());
    exp_q.delete();
    got_q.delete();
  endtask

  // Collects characters that the demodulator accepted as well framed.
  always @(posedge rx_strobe)
  begin
    if (rx_frame_ok)
      got_q.push_back(rx_byte);
  end

  // Both switches must follow the same coded stream at every cycle.
  always @(negedge ref_clk)
  begin
    if (!rst)
      check("switch pair", modulation_switch_a_r, modulation_switch_b_r);
  end

  // Hang guard.
  initial
  begin
    #500us;
    $display("unexpected run time limit");
    err_count++;
    test_done();
  end

  // Main sequence.
  initial
  begin
    step(5);
    check("ilim at reset", 32'h00000190, comm_ilim_ma_r);
    check("rect at reset", rx_comm_pkg::RECT_OFF, rect_mode_r);
    check("status oe at reset", 0, power_good_status_n_oe_r);
    rst <= 1'b0;
    step(1);
    count_while(temp_bias_window_r, 1'b0, 10, n);
    check("bias pin oe", 1, temp_bias_pin_oe_r);
    check("bias pin level", 1, temp_bias_pin_o_r);
    count_while(temp_bias_window_r, 1'b1, 200, n);
    check("bias window length", 40, n);
    temp_control_pin_cmp <= 1'b1;
    check("bias pin released", 0, temp_bias_pin_oe_r);
    count_while(temp_bias_window_r, 1'b0, 200, n);
    check("priority watch length", 30, n);
    step(2);
    check("hot flag", 1, temp_hot_r);
    check("cold flag", 0, temp_cold_r);
    check("control flag", 1, temp_control_r);
    // Random comparator levels, held through a whole window and watch interval.
    for (int i = 0; i < 3; i++)
    begin
      count_while(temp_bias_window_r, 1'b0, 200, n);
      ts_lv = 3'(xs());
      ts_hot_cmp <= ts_lv[0];
      ts_cold_cmp <= ts_lv[1];
      temp_control_pin_cmp <= ts_lv[2];
      count_while(temp_bias_window_r, 1'b1, 200, n);
      check("hot flag", ts_lv[0], temp_hot_r);
      check("cold flag", ts_lv[1], temp_cold_r);
      count_while(temp_bias_window_r, 1'b0, 200, n);
      check("control flag", ts_lv[2], temp_control_r);
    end
    supply_enable_req <= 1'b1;
    step(6);
    check("supply before converge", 0, supply_enable_r);
    check("status before converge", 0, power_good_status_n_oe_r);
    vrect_converged <= 1'b1;
    step(6);
    check("supply enabled", 1, supply_enable_r);
    check("status pulled", 1, power_good_status_n_oe_r);
    check("status level", 0, power_good_status_n_o_r);
    supply_enable_req <= 1'b0;
    step(4);
    check("status released", 0, power_good_status_n_oe_r);
    check("rect below lockout", rx_comm_pkg::RECT_OFF, rect_mode_r);
    vrect_above_uvlo <= 1'b1;
    step(6);
    check("rect half", rx_comm_pkg::RECT_HALF, rect_mode_r);
    load_ma <= 10'h079;
    step(3);
    check("rect full", rx_comm_pkg::RECT_FULL, rect_mode_r);
    load_ma <= 10'h064;
    step(3);
    check("rect held full", rx_comm_pkg::RECT_FULL, rect_mode_r);
    load_ma <= 10'h063;
    step(3);
    check("rect back half", rx_comm_pkg::RECT_HALF, rect_mode_r);
    load_ma <= 10'h078;
    step(3);
    check("rect stays half", rx_comm_pkg::RECT_HALF, rect_mode_r);
    for (int i = 0; i < 10; i++)
    begin
      n = (i < 6) ? ilim_tab[i] : (xs() & 32'h3ff);
      load_ma <= n[9:0];
      step(3);
      check("current limit", (n > 300) ? n + 50 : 400, comm_ilim_ma_r);
    end
    count_while(err_pkt_due_r, 1'b0, 100, n);
    step(1);
    count_while(err_pkt_due_r, 1'b0, 100, n);
    check("fast error period", 19, n);
    vrect_at_target <= 1'b1;
    step(1);
    count_while(err_pkt_due_r, 1'b0, 100, n);
    step(1);
    count_while(err_pkt_due_r, 1'b0, 100, n);
    check("slow error period", 49, n);
    // At target the watch interval takes the standard length.
    count_while(temp_bias_window_r, 1'b0, 200, n);
    count_while(temp_bias_window_r, 1'b1, 200, n);
    count_while(temp_bias_window_r, 1'b0, 200, n);
    check("standard watch length", 60, n);
    send_packet(1, 8'h00);
    send_packet(3, 8'hff);
    send_packet(4, 8'(xs() >> 4));
    test_done();
  end
endmodule
